// >>> wlm_write_leveling.sv
/*
 Write leveling logic of a DDR3 SDRAM: mode entry and exit, strobe-only
 termination, and per-lane sampling of the clock level on strobe edges.
 Assumes commands are already decoded on clk, and that each strobe rises
 once per trial with the clock level steady around it.
*/
// Notes on behaviour
// [R1] In leveling, ODT switches only strobe termination; data termination stays off.
// [R2] Controller limits nominal termination to RZQ/2, /4, /6 with outputs on; the controller model leaves the nominal termination bits at zero.
// [R3] Controller enters leveling by writing MR1 bit 7 to one.
// [R4] After entry DQ carries no meaningful value until feedback starts.
// [R5] Controller issues only NOP or Deselect, plus the exit MRS.
// [R6] Controller disables outputs of other ranks with MR1 bit 12 set.
// [R7] Controller waits tMOD after entry before asserting ODT.
// [R8] Strobe termination is applied after ODT before strobes are driven.
// [R9] Controller sends one strobe edge per trial after tDQSL and tWLMRD.
// [R10] Each strobe rise samples the clock level, returned on DQ within tWLO; here DQ updates on the third clk edge after the rise.
// [R11] No read strobe is driven while feedback is returned.
// [R12] Controller steps strobe delay and locks on a 0 to 1 change.
// [R13] Controller stops strobes after last edge; DQ undefined until tMOD.
// [R14] Controller drives ODT low for the whole exit.
// [R15] Controller disables leveling only after termination is off.
// [R16] Controller waits tMRD before next MRS, tMOD before other commands.
// [R17] Writing MR1 bit 7 to zero leaves leveling mode.
// [R18] Upper strobe feeds the upper byte, lower strobe the lower byte.
// [R19] Controller keeps each locked lane delay for later writes.
`timescale 1ns/1ps
module wlm_write_leveling
    import wlm_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic mrsValid,
    input wire logic [MRS_BANK_W-1:0] mrsBank,
    input wire logic [MRS_ADDR_W-1:0] mrsAddr,
    input wire logic odtPin,
    input wire logic ckLevel,
    input wire logic dqsLowClk,
    input wire logic dqsUpClk,
    output logic [DQ_W-1:0] dqOut,
    output logic [DQ_W-1:0] dqOe_n,
    output logic readDqsOe_n,
    output logic rttStrobeOn,
    output logic rttDataOn,
    output logic wlActive,
    output logic qoffActive
);
    // ------------------------------------------------------------
    // Reset release and ODT synchroniser
    // ------------------------------------------------------------
    logic rstS1_q;
    logic rstN_q;
    logic odtS1_q;
    logic odtS2_q;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rstS1_q <= 1'b0;
            rstN_q <= 1'b0;
            odtS1_q <= 1'b0;
            odtS2_q <= 1'b0;
        end
        else
        begin
            rstS1_q <= 1'b1;
            rstN_q <= rstS1_q;
            odtS1_q <= odtPin;
            odtS2_q <= odtS1_q;
        end
    end

    // ------------------------------------------------------------
    // Strobe domains: clock level sampled on each strobe rise
    // ------------------------------------------------------------
    logic lowSample_q;
    logic lowTog_q;
    logic upSample_q;
    logic upTog_q;

    always_ff @(posedge dqsLowClk or negedge rstN_q)
    begin
        if (!rstN_q)
        begin
            lowSample_q <= 1'b0;
            lowTog_q <= 1'b0;
        end
        else
        begin
            lowSample_q <= ckLevel; // see [R10]
            lowTog_q <= ~lowTog_q;
        end
    end

    always_ff @(posedge dqsUpClk or negedge rstN_q)
    begin
        if (!rstN_q)
        begin
            upSample_q <= 1'b0;
            upTog_q <= 1'b0;
        end
        else
        begin
            upSample_q <= ckLevel; // see [R10]
            upTog_q <= ~upTog_q;
        end
    end

    // ------------------------------------------------------------
    // Toggle crossing into clk; sample is steady once toggle is seen
    // ------------------------------------------------------------
    logic [LANES-1:0] togS1_q;
    logic [LANES-1:0] togS2_q;
    logic [LANES-1:0] togS3_q;
    logic [LANES-1:0] trialSeen;

    always_ff @(posedge clk or negedge rstN_q)
    begin
        if (!rstN_q)
        begin
            togS1_q <= '0;
            togS2_q <= '0;
            togS3_q <= '0;
        end
        else
        begin
            togS1_q <= {upTog_q, lowTog_q};
            togS2_q <= togS1_q;
            togS3_q <= togS2_q;
        end
    end

    assign trialSeen = togS2_q ^ togS3_q;

    // ------------------------------------------------------------
    // Mode state and pin drivers
    // ------------------------------------------------------------
    wlm_state_t state_q;
    wlm_state_t state_d;
    logic qoff_q;
    logic qoff_d;
    logic [LANES-1:0] fbValid_q;
    logic [LANES-1:0] fbValid_d;
    logic [DQ_W-1:0] dq_q;
    logic [DQ_W-1:0] dq_d;
    logic [DQ_W-1:0] oe_q;
    logic [DQ_W-1:0] oe_d;
    logic rttS_q;
    logic rttS_d;
    logic mr1Write;
    logic [LANES-1:0] laneSample;

    assign mr1Write = mrsValid && (mrsBank == MR1_SEL);
    assign laneSample = {upSample_q, lowSample_q};

    always_comb
    begin
        state_d = state_q;
        qoff_d = qoff_q;
        fbValid_d = fbValid_q;
        dq_d = dq_q;
        oe_d = DQ_OE_N_RST;
        if (mr1Write)
        begin
            qoff_d = mrsAddr[MR1_QOFF_BIT];
            if (mrsAddr[MR1_WL_BIT])
            begin
                if (state_q == WL_OFF)
                begin
                    state_d = WL_WAIT;
                    fbValid_d = '0;
                end
            end
            else
            begin
                state_d = WL_OFF; // see [R17]
                fbValid_d = '0;
            end
        end
        else if (state_q != WL_OFF)
        begin
            for (int i = 0; i < LANES; i++)
            begin
                if (trialSeen[i])
                begin
                    fbValid_d[i] = 1'b1;
                    dq_d[i*LANE_W +: LANE_W] = {LANE_W{laneSample[i]}}; // see [R10] [R18]
                end
            end
            if (trialSeen != '0)
            begin
                state_d = WL_FEED;
            end
        end
        // Lanes drive only in leveling with outputs enabled; content is
        // meaningless until the first trial of that lane
        if (state_d != WL_OFF && !qoff_d)
        begin
            oe_d = '0; // see [R4]
        end
        rttS_d = (state_d != WL_OFF) && odtS2_q; // see [R1] [R8]
    end

    always_ff @(posedge clk or negedge rstN_q)
    begin
        if (!rstN_q)
        begin
            state_q <= WL_OFF;
            qoff_q <= 1'b0;
            fbValid_q <= '0;
            dq_q <= DQ_RST;
            oe_q <= DQ_OE_N_RST;
            rttS_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            qoff_q <= qoff_d;
            fbValid_q <= fbValid_d;
            dq_q <= dq_d;
            oe_q <= oe_d;
            rttS_q <= rttS_d;
        end
    end

    logic active_q;
    always_ff @(posedge clk or negedge rstN_q)
    begin
        if (!rstN_q)
        begin
            active_q <= 1'b0;
        end
        else
        begin
            active_q <= (state_d != WL_OFF);
        end
    end

    assign dqOut = dq_q;
    assign dqOe_n = oe_q;
    assign rttStrobeOn = rttS_q;
    // Data termination is never enabled by this block
    assign rttDataOn = 1'b0; // see [R1]
    // No read strobe is ever driven during leveling
    assign readDqsOe_n = 1'b1; // see [R11]
    assign wlActive = active_q;
    assign qoffActive = qoff_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_rtt_follows_odt;
        @(posedge clk) disable iff (!rstN_q)
        (wlActive && $past(wlActive) && !mr1Write) |=> (rttStrobeOn == $past(odtS2_q));
    endproperty
    a_rtt_follows_odt: assert property (p_rtt_follows_odt) // see [R1]
        else $error("strobe termination does not follow ODT");

    property p_no_data_rtt;
        @(posedge clk) disable iff (!rstN_q)
        rttStrobeOn |-> !rttDataOn && wlActive;
    endproperty
    a_no_data_rtt: assert property (p_no_data_rtt) // see [R1]
        else $error("data termination on or strobe termination outside leveling");

    property p_odt_rise_rtt;
        @(posedge clk) disable iff (!rstN_q)
        (wlActive && $rose(odtS2_q) && !mr1Write) |=> rttStrobeOn;
    endproperty
    a_odt_rise_rtt: assert property (p_odt_rise_rtt) // see [R8]
        else $error("strobe termination late after ODT");

    property p_entry_no_feedback;
        @(posedge clk) disable iff (!rstN_q)
        $rose(wlActive) |-> (fbValid_q == '0);
    endproperty
    a_entry_no_feedback: assert property (p_entry_no_feedback) // see [R4]
        else $error("feedback marked valid at entry");

    property p_low_lane;
        @(posedge clk) disable iff (!rstN_q)
        (wlActive && trialSeen[0] && !mr1Write) |=> (dqOut[LANE_W-1:0] == {LANE_W{$past(lowSample_q)}});
    endproperty
    a_low_lane: assert property (p_low_lane) // see [R10] [R18]
        else $error("lower lane feedback wrong");

    property p_up_lane;
        @(posedge clk) disable iff (!rstN_q)
        (wlActive && trialSeen[1] && !trialSeen[0] && !mr1Write) |=>
            (dqOut[DQ_W-1:LANE_W] == {LANE_W{$past(upSample_q)}}) && $stable(dqOut[LANE_W-1:0]);
    endproperty
    a_up_lane: assert property (p_up_lane) // see [R18]
        else $error("upper lane feedback wrong or crosstalk");

    property p_no_read_strobe;
        @(posedge clk) disable iff (!rstN_q)
        (dqOe_n != DQ_OE_N_RST) |-> readDqsOe_n && wlActive && !qoffActive;
    endproperty
    a_no_read_strobe: assert property (p_no_read_strobe) // see [R11]
        else $error("DQ driven with read strobe or outside leveling");

    property p_exit;
        @(posedge clk) disable iff (!rstN_q)
        (mr1Write && !mrsAddr[MR1_WL_BIT]) |=> !wlActive && !rttStrobeOn && (dqOe_n == DQ_OE_N_RST);
    endproperty
    a_exit: assert property (p_exit) // see [R17]
        else $error("leveling mode not left on MR1 bit 7 clear");
endmodule : wlm_write_leveling

// >>> wlm_pkg.sv
/*
 Constants for the write leveling block of a DDR3 SDRAM.
 Assumes a core clock of 125 MHz and a x16 part with two byte lanes.
*/
package wlm_pkg;
    // ------------------------------------------------------------
    // Mode register decode
    // ------------------------------------------------------------
    localparam int MRS_BANK_W = 3;
    localparam int MRS_ADDR_W = 16;
    localparam logic [MRS_BANK_W-1:0] MR1_SEL = 3'h1;
    localparam int MR1_WL_BIT = 7;
    localparam int MR1_QOFF_BIT = 12;
    // ------------------------------------------------------------
    // Data lanes
    // ------------------------------------------------------------
    localparam int LANE_W = 8;
    localparam int LANES = 2;
    localparam int DQ_W = LANE_W * LANES;
    // ------------------------------------------------------------
    // Timing and reset values
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int T_WLO_PS = 7500;
    // Longest time rounds down, never below one cycle
    localparam int T_WLO_CYC = (T_WLO_PS / CLK_PERIOD_PS) < 1 ? 1 : (T_WLO_PS / CLK_PERIOD_PS);
    localparam logic [DQ_W-1:0] DQ_RST = 16'h0000;
    localparam logic [DQ_W-1:0] DQ_OE_N_RST = 16'hFFFF;
    typedef enum logic [1:0] {
        WL_OFF = 2'b00,
        WL_WAIT = 2'b01,
        WL_FEED = 2'b10
    } wlm_state_t;
endpackage : wlm_pkg

// >>> wlm_ctrl_model.sv
/*
 Controller-side model for write leveling: mode register writes, ODT,
 clock level and single strobe pulses, each held high for 16 ns.
 Assumes the device core runs on clk; strobes idle low between trials.
*/
`timescale 1ns/1ps
module wlm_ctrl_model
    import wlm_pkg::*;
#(
    parameter int T_MOD = 12,
    parameter int T_MRD = 4,
    parameter int T_DQSEN = 25
)
(
    input wire logic clk,
    output logic mrsValid,
    output logic [MRS_BANK_W-1:0] mrsBank,
    output logic [MRS_ADDR_W-1:0] mrsAddr,
    output logic odtPin,
    output logic ckLevel,
    output logic dqsLowClk,
    output logic dqsUpClk
);
    initial
    begin
        mrsValid = 1'h0;
        mrsBank = 3'h0;
        mrsAddr = 16'h0000;
        odtPin = 1'h0;
        ckLevel = 1'h0;
        dqsLowClk = 1'h0;
        dqsUpClk = 1'h0;
    end

    // Only mode register writes are ever issued, everything else is NOP
    task automatic mrs(input logic [MRS_BANK_W-1:0] b, input logic [MRS_ADDR_W-1:0] a);
        @(posedge clk);
        mrsValid <= 1'h1;
        mrsBank <= b;
        mrsAddr <= a;
        @(posedge clk);
        mrsValid <= 1'h0;
        mrsAddr <= ~a;
    endtask : mrs

    // ODT level changes just after a core clock edge
    task automatic odt(input logic lvl);
        @(posedge clk);
        odtPin <= lvl;
    endtask : odt

    task automatic enter(input logic qoff);
        // Nominal termination bits stay zero in every entry write
        mrs(MR1_SEL, {3'h0, qoff, 4'h0, 1'h1, 7'h00});
        repeat (T_MOD) @(posedge clk);
        odtPin <= 1'h1;
        repeat (T_DQSEN) @(posedge clk);
    endtask : enter

    // One rising strobe edge per trial, clock level steady around it
    task automatic trial(input logic upper, input logic lvl);
        ckLevel = lvl;
        #5;
        if (upper)
            dqsUpClk = 1'h1;
        else
            dqsLowClk = 1'h1;
        #16;
        dqsUpClk = 1'h0;
        dqsLowClk = 1'h0;
        #40;
    endtask : trial

    task automatic leave();
        @(posedge clk);
        odtPin <= 1'h0;
        repeat (T_DQSEN) @(posedge clk);
        mrs(MR1_SEL, 16'h0000);
        repeat (T_MRD) @(posedge clk);
        repeat (T_MOD) @(posedge clk);
    endtask : leave
endmodule : wlm_ctrl_model

// >>> tb_dram_write_leveling_mode.sv
/*
 Self-checking bench for the write leveling block.
 Assumes the controller model drives every device input except clk and nrst.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_dram_write_leveling_mode;
    import wlm_pkg::*;
    logic clk;
    logic nrst;
    logic mrsValid;
    logic [MRS_BANK_W-1:0] mrsBank;
    logic [MRS_ADDR_W-1:0] mrsAddr;
    logic odtPin;
    logic ckLevel;
    logic dqsLowClk;
    logic dqsUpClk;
    logic [DQ_W-1:0] dqOut;
    logic [DQ_W-1:0] dqOe_n;
    logic readDqsOe_n;
    logic rttStrobeOn;
    logic rttDataOn;
    logic wlActive;
    logic qoffActive;
    logic [DQ_W-1:0] expDq;
    int fails;
    int total_checks;
    int cycles;

    initial
    begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    wlm_ctrl_model u_ctrl (.clk(clk), .mrsValid(mrsValid), .mrsBank(mrsBank),
        .mrsAddr(mrsAddr), .odtPin(odtPin), .ckLevel(ckLevel),
        .dqsLowClk(dqsLowClk), .dqsUpClk(dqsUpClk));

    wlm_write_leveling u_dut (.clk(clk), .nrst(nrst), .mrsValid(mrsValid),
        .mrsBank(mrsBank), .mrsAddr(mrsAddr), .odtPin(odtPin), .ckLevel(ckLevel),
        .dqsLowClk(dqsLowClk), .dqsUpClk(dqsUpClk), .dqOut(dqOut), .dqOe_n(dqOe_n),
        .readDqsOe_n(readDqsOe_n), .rttStrobeOn(rttStrobeOn), .rttDataOn(rttDataOn),
        .wlActive(wlActive), .qoffActive(qoffActive));

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            close_out();
        end
    end

    task automatic t_reset();
        `CHK(dqOe_n, DQ_OE_N_RST)
        `CHK(dqOut, DQ_RST)
        `CHK(readDqsOe_n, 1'h1)
        `CHK(rttDataOn, 1'h0)
        `CHK(rttStrobeOn, 1'h0)
        `CHK(wlActive, 1'h0)
        `CHK(qoffActive, 1'h0)
    endtask : t_reset

    task automatic t_enter();
        u_ctrl.mrs(3'h2, 16'h0080);
        repeat (2) @(posedge clk);
        #1;
        `CHK(wlActive, 1'h0)
        u_ctrl.enter(1'h0);
        #1;
        `CHK(wlActive, 1'h1)
        `CHK(dqOe_n, 16'h0000)
        `CHK(rttStrobeOn, 1'h1)
        `CHK(rttDataOn, 1'h0)
        // ODT low reaches the strobe termination on the third edge
        u_ctrl.odt(1'h0);
        repeat (2) @(posedge clk);
        #1;
        `CHK(rttStrobeOn, 1'h1)
        @(posedge clk);
        #1;
        `CHK(rttStrobeOn, 1'h0)
        `CHK(rttDataOn, 1'h0)
        u_ctrl.odt(1'h1);
    endtask : t_enter

    // Lanes answer independently; a 0 then 1 pattern mimics the lock point
    task automatic t_feedback();
        logic lvls [4];
        lvls = '{1'h0, 1'h1, 1'h1, 1'h0};
        expDq = DQ_RST;
        for (int i = 0; i < 4; i++)
        begin
            u_ctrl.trial(i[0], lvls[i]);
            if (i[0])
                expDq[15:8] = {8{lvls[i]}};
            else
                expDq[7:0] = {8{lvls[i]}};
            repeat (6) @(posedge clk);
            #1;
            `CHK(dqOut, expDq)
            `CHK(readDqsOe_n, 1'h1)
        end
    endtask : t_feedback

    task automatic t_exit();
        u_ctrl.leave();
        #1;
        `CHK(wlActive, 1'h0)
        `CHK(dqOe_n, 16'hFFFF)
        `CHK(rttStrobeOn, 1'h0)
        // A lower strobe outside leveling, at the level 1 the lower lane already holds, leaves the feedback unchanged
        u_ctrl.trial(1'h0, 1'h1);
        repeat (6) @(posedge clk);
        #1;
        `CHK(dqOut, expDq)
    endtask : t_exit

    task automatic t_qoff();
        u_ctrl.enter(1'h1);
        #1;
        `CHK(wlActive, 1'h1)
        `CHK(qoffActive, 1'h1)
        `CHK(dqOe_n, 16'hFFFF)
        `CHK(rttStrobeOn, 1'h1)
        u_ctrl.leave();
        #1;
        `CHK(qoffActive, 1'h0)
    endtask : t_qoff

    // Reset in mid leveling drops the mode and all pin drivers at once
    task automatic t_midreset();
        u_ctrl.enter(1'h0);
        @(posedge clk);
        nrst <= 1'h0;
        #1;
        `CHK(wlActive, 1'h0)
        `CHK(dqOe_n, DQ_OE_N_RST)
        `CHK(rttStrobeOn, 1'h0)
        `CHK(dqOut, DQ_RST)
        repeat (3) @(posedge clk);
        nrst <= 1'h1;
        u_ctrl.leave();
        #1;
        `CHK(wlActive, 1'h0)
        `CHK(rttStrobeOn, 1'h0)
        `CHK(dqOe_n, DQ_OE_N_RST)
    endtask : t_midreset

    initial
    begin
        nrst = 1'h0;
        fails = 0;
        total_checks = 0;
        cycles = 0;
        @(posedge clk);
        #1;
        t_reset();
        @(posedge clk);
        nrst <= 1'h1;
        repeat (4) @(posedge clk);
        t_enter();
        t_feedback();
        t_exit();
        t_qoff();
        t_midreset();
        close_out();
    end
endmodule : tb_dram_write_leveling_mode
